// ===== core/useq_stack.sv
// Microsequencer next-address selection, call/return stack and read mode
//
// Functional notes
// - Op HLH without decrement: push and call only on low condition path.
// - Op HHL pushes on both paths; low calls target, high calls alternate.
// - Call ops with decrement, zero high: take the zero-path alternate.
// - Source HLH selects 16-way A-prime low, B-prime high.
// - Push depends on condition and zero; call completes in one cycle.
// - Op LHH, no decrement: low returns from stack and pops.
// - Op LHH with decrement and zero high: continue or branch A/B.
// - Op all low clears both pointers and drives next address zero.
// - Op LLH with low condition clears pointers, address unaffected.
// - Op all high with output select high enters read mode.
// - Read mode: each edge presents entry at read pointer, then decrements it unless it is zero.
// - Warning output high on read while stack holds one word.
// - Read leaves stack pointer and contents unchanged.
// - Push and pop keep read pointer equal to stack pointer.
// - Interrupt accepted during any instruction, pushes and pops included.
// - Source 110, op 111, select 0: continue with no stack action.
// - Source 110, op 010: continue and pop.
// - Source 110, op 100: continue and push counter.
// - Source 000, op 111, condition high: branch to A port.
// - Continue advances with increment high, repeats when it was low.
// - 16-way target is data upper twelve bits with status nibble.
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module useq_stack
    import useq_stack_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] next_source_select_i,
    input wire logic [2:0] stack_op_code_i,
    input wire logic output_select_flag_i,
    input wire logic cond_code_n_i,
    input wire logic counter_dec_i,
    input wire logic counter_zero_i,
    input wire logic inc_ctrl_i,
    input wire logic int_link_n_i,
    input wire logic [NIB_W-1:0] status_nibble_in_i,
    input wire logic [ADDR_W-1:0] data_port_a_i,
    output logic [ADDR_W-1:0] data_port_a_o,
    output logic data_port_a_oe_o,
    input wire logic [ADDR_W-1:0] data_port_b_i,
    input wire logic addr_out_enable_n_i,
    input wire logic [ADDR_W-1:0] next_addr_i,
    output logic [ADDR_W-1:0] next_addr_o,
    output logic next_addr_oe_o,
    output logic stack_warn_read_err_o,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [WB_ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [ADDR_W-1:0] stack_mem [STACK_DEPTH];
    logic [PTR_W-1:0] sp_q;
    logic [PTR_W-1:0] rp_q;
    logic [ADDR_W-1:0] mpc_q;
    logic [ADDR_W-1:0] int_ret_q;
    logic oe_n_prev_q;
    logic [ADDR_W-1:0] rd_data_q;
    logic rd_oe_q;
    logic [6:0] warn_level_q;
    logic ovf_q;
    logic unf_q;
    logic rd_err_q;
    logic ack_q;
    logic [31:0] rdat_q;

    ////////////////////////////////////////////////////////////////////////
    // Path and target selection
    wire logic main_path = ~cond_code_n_i & ~(counter_dec_i & counter_zero_i);
    wire logic zero_path = ~cond_code_n_i & counter_dec_i & counter_zero_i;
    wire logic hi_path = cond_code_n_i;
    wire logic [IDX_W-1:0] top_idx = IDX_W'(sp_q - PTR_ONE);
    wire logic [IDX_W-1:0] rd_idx = IDX_W'(rp_q - PTR_ONE);
    wire logic [ADDR_W-1:0] top_val = stack_mem[top_idx];
    wire logic [ADDR_W-1:0] a16 = {data_port_a_i[ADDR_W-1:NIB_W],
                                   status_nibble_in_i};
    wire logic [ADDR_W-1:0] b16 = {data_port_b_i[ADDR_W-1:NIB_W],
                                   status_nibble_in_i};
    src_e main_src;
    src_e hi_src;
    src_e zero_src;
    src_e act_src;
    logic [ADDR_W-1:0] target;

    always_comb begin
        main_src = SRC_STACK;
        hi_src = SRC_CONT;
        zero_src = SRC_CONT;
        case (next_source_select_i)
            3'h0: begin
                hi_src = SRC_A;
            end
            3'h1: begin
                hi_src = SRC_B;
            end
            3'h2: begin
                zero_src = SRC_A;
            end
            3'h3: begin
                zero_src = SRC_B;
            end
            3'h4: begin
                main_src = SRC_A;
                hi_src = SRC_B;
            end
            3'h5: begin
                main_src = SRC_A16;
                hi_src = SRC_B16;
            end
            3'h6: begin
                main_src = SRC_A;
                zero_src = SRC_STACK;
            end
            3'h7: begin
                main_src = SRC_B;
                zero_src = SRC_STACK;
            end
            default: begin
                main_src = SRC_STACK;
            end
        endcase
    end

    assign act_src = hi_path ? hi_src : (zero_path ? zero_src : main_src);

    // Continue source is the counter register, advanced or held per cycle
    always_comb begin
        case (act_src)
            SRC_STACK: target = top_val;
            SRC_A: target = data_port_a_i;
            SRC_B: target = data_port_b_i;
            SRC_A16: target = a16;
            SRC_B16: target = b16;
            SRC_CONT: target = mpc_q;
            default: target = ADDR_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack operation decode
    wire logic op_reset = stack_op_code_i == OP_RESET;
    wire logic do_clear = op_reset |
        (stack_op_code_i == OP_CLEAR & main_path);
    wire logic do_push = (stack_op_code_i == OP_PUSH_BOTH) |
        (stack_op_code_i == OP_PUSH_ALT & ~main_path) |
        (stack_op_code_i == OP_PUSH_MAIN & main_path);
    wire logic do_pop = (stack_op_code_i == OP_POP_ALT & ~main_path) |
        (stack_op_code_i == OP_POP_MAIN & main_path);
    wire logic read_mode = (stack_op_code_i == OP_HOLD) &
        output_select_flag_i;
    wire logic full = sp_q == PTR_FULL;
    wire logic empty = sp_q == '0;
    wire logic push_ok = do_push & ~full & ~do_clear;
    wire logic pop_ok = do_pop & ~empty & ~do_clear;
    // Handler's first push stores the interrupt return linkage
    wire logic link_sel = ~int_link_n_i & ~status_nibble_in_i[LINK_BIT];
    wire logic [ADDR_W-1:0] push_val = link_sel ? int_ret_q : mpc_q;

    ////////////////////////////////////////////////////////////////////////
    // Next address bus; the controller may override it for an interrupt
    assign next_addr_o = op_reset ? ADDR_ZERO : target;
    assign next_addr_oe_o = ~addr_out_enable_n_i;
    wire logic [ADDR_W-1:0] y_eff =
        addr_out_enable_n_i ? next_addr_i : next_addr_o;
    wire logic [ADDR_W-1:0] mpc_d =
        inc_ctrl_i ? ADDR_W'(y_eff + ADDR_ONE) : y_eff;
    wire logic warn_hit = (warn_level_q != '0) & (sp_q >= warn_level_q);
    assign stack_warn_read_err_o = (read_mode & sp_q == PTR_ONE) |
        warn_hit;
    assign data_port_a_o = rd_data_q;
    assign data_port_a_oe_o = rd_oe_q;

    always_ff @(posedge clk_i) begin
        mpc_q <= rst_i ? ADDR_ZERO : mpc_d;
        oe_n_prev_q <= rst_i ? 1'b0 : addr_out_enable_n_i;
    end

    // Return point is the address the sequencer had chosen when overridden
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_ret_q <= ADDR_ZERO;
        end else if (addr_out_enable_n_i & ~oe_n_prev_q) begin
            int_ret_q <= next_addr_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack and pointers
    always_ff @(posedge clk_i) begin
        if (push_ok) begin
            stack_mem[IDX_W'(sp_q)] <= push_val;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i | do_clear) begin
            sp_q <= '0;
        end else if (push_ok) begin
            sp_q <= sp_q + PTR_ONE;
        end else if (pop_ok) begin
            sp_q <= sp_q - PTR_ONE;
        end
    end

    // Read pointer follows the stack pointer except while reading
    always_ff @(posedge clk_i) begin
        if (rst_i | do_clear) begin
            rp_q <= '0;
        end else if (push_ok) begin
            rp_q <= sp_q + PTR_ONE;
        end else if (pop_ok) begin
            rp_q <= sp_q - PTR_ONE;
        end else if (read_mode & rp_q != '0) begin
            rp_q <= rp_q - PTR_ONE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_q <= ADDR_ZERO;
            rd_oe_q <= 1'b0;
        end else begin
            rd_oe_q <= read_mode;
            if (read_mode) begin
                rd_data_q <= stack_mem[rd_idx];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, unmapped reads return zero
    wire logic wb_req = cyc_i & stb_i & ~ack_q;
    wire logic hit_ctrl = adr_i == REG_CTRL;
    wire logic hit_status = adr_i == REG_STATUS;
    wire logic wr_ctrl = wb_req & we_i & hit_ctrl & sel_i[0];
    wire logic wr_status = wb_req & we_i & hit_status & sel_i[2];
    wire logic [31:0] status_word = (32'(sp_q) << ST_SP_LSB) |
        (32'(rp_q) << ST_RP_LSB) | (32'(ovf_q) << ST_OVF_BIT) |
        (32'(unf_q) << ST_UNF_BIT) | (32'(rd_err_q) << ST_RD_BIT);
    wire logic [31:0] rd_mux = hit_ctrl ? 32'(warn_level_q) :
        (hit_status ? status_word : 32'h00000000);
    assign ack_o = ack_q;
    assign dat_o = rdat_q;

    always_ff @(posedge clk_i) begin
        ack_q <= rst_i ? 1'b0 : wb_req;
        rdat_q <= rst_i ? 32'h00000000 : rd_mux;
        if (rst_i) begin
            warn_level_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            warn_level_q <= dat_i[6:0];
        end
    end

    // Sticky errors: a new event wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
            rd_err_q <= 1'b0;
        end else begin
            ovf_q <= (do_push & full & ~do_clear) |
                (ovf_q & ~(wr_status & dat_i[ST_OVF_BIT]));
            unf_q <= (do_pop & empty & ~do_clear) |
                (unf_q & ~(wr_status & dat_i[ST_UNF_BIT]));
            rd_err_q <= (read_mode & sp_q == PTR_ONE) |
                (rd_err_q & ~(wr_status & dat_i[ST_RD_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ret_sel;
        stack_op_code_i == OP_POP_MAIN && !next_source_select_i[2] &&
            !cond_code_n_i && !counter_dec_i && !empty;
    endsequence
    sequence s_popped(logic [PTR_W-1:0] old);
        sp_q == old - PTR_ONE && rp_q == old - PTR_ONE;
    endsequence

    property p_return;
        logic [PTR_W-1:0] old;
        (s_ret_sel, old = sp_q) |-> next_addr_o == top_val
            ##1 s_popped(old);
    endproperty
    a_return: assert property (p_return)
        else $error("return did not branch to stack and pop");

    property p_call_main;
        logic [PTR_W-1:0] old;
        (stack_op_code_i == OP_PUSH_MAIN && next_source_select_i == 3'h4 &&
            main_path && !full, old = sp_q)
            |-> next_addr_o == data_port_a_i ##1 sp_q == old + PTR_ONE;
    endproperty
    a_call_main: assert property (p_call_main)
        else $error("conditional call did not push and branch");

    property p_no_push_hi;
        stack_op_code_i == OP_PUSH_MAIN && hi_path |=> $stable(sp_q);
    endproperty
    a_no_push_hi: assert property (p_no_push_hi)
        else $error("push on high path of call-low opcode");

    property p_reset_op;
        op_reset |-> next_addr_o == ADDR_ZERO ##1 sp_q == '0 && rp_q == '0;
    endproperty
    a_reset_op: assert property (p_reset_op)
        else $error("reset opcode did not clear or zero address");

    property p_clear_ptr;
        stack_op_code_i == OP_CLEAR && main_path
            |-> next_addr_o == target ##1 sp_q == '0;
    endproperty
    a_clear_ptr: assert property (p_clear_ptr)
        else $error("clear pointers failed");

    property p_read;
        logic [PTR_W-1:0] r;
        (read_mode && rp_q != '0, r = rp_q) |=> rp_q == r - PTR_ONE &&
            $stable(sp_q) && data_port_a_oe_o;
    endproperty
    a_read: assert property (p_read)
        else $error("read mode step wrong");

    property p_warn;
        read_mode && sp_q == PTR_ONE |-> stack_warn_read_err_o;
    endproperty
    a_warn: assert property (p_warn)
        else $error("missing read warning at last word");

    property p_rp_track;
        (push_ok || pop_ok) |=> rp_q == sp_q;
    endproperty
    a_rp_track: assert property (p_rp_track)
        else $error("read pointer diverged from stack pointer");

    property p_16way;
        next_source_select_i == 3'h5 && hi_path && !op_reset
            |-> next_addr_o == {data_port_b_i[15:4], status_nibble_in_i};
    endproperty
    a_16way: assert property (p_16way)
        else $error("16-way target wrong");

    property p_cont;
        next_source_select_i == 3'h6 && hi_path && !op_reset && inc_ctrl_i
            && !addr_out_enable_n_i |=> next_source_select_i != 3'h6 ||
            !hi_path || op_reset || next_addr_o == $past(next_addr_o) + 1;
    endproperty
    a_cont: assert property (p_cont)
        else $error("continue did not advance");

endmodule : useq_stack

// ===== core/useq_stack_pkg.sv
// Constants and encodings for the microsequencer call/return stack block
package useq_stack_pkg;
    localparam int ADDR_W = 16;
    localparam int STACK_DEPTH = 64;
    localparam int PTR_W = 7;
    localparam int IDX_W = 6;
    localparam int NIB_W = 4;
    localparam int LINK_BIT = 1;

    // Stack operation codes
    localparam logic [2:0] OP_RESET = 3'h0;
    localparam logic [2:0] OP_CLEAR = 3'h1;
    localparam logic [2:0] OP_POP_ALT = 3'h2;
    localparam logic [2:0] OP_POP_MAIN = 3'h3;
    localparam logic [2:0] OP_PUSH_ALT = 3'h4;
    localparam logic [2:0] OP_PUSH_MAIN = 3'h5;
    localparam logic [2:0] OP_PUSH_BOTH = 3'h6;
    localparam logic [2:0] OP_HOLD = 3'h7;

    // Address sources
    typedef enum logic [2:0] {
        SRC_STACK = 3'b000,
        SRC_A = 3'b001,
        SRC_B = 3'b010,
        SRC_A16 = 3'b011,
        SRC_B16 = 3'b100,
        SRC_CONT = 3'b101
    } src_e;

    // Register map, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int WB_ADDR_W = 4;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam int ST_SP_LSB = 0;
    localparam int ST_RP_LSB = 8;
    localparam int ST_OVF_BIT = 16;
    localparam int ST_UNF_BIT = 17;
    localparam int ST_RD_BIT = 18;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
    localparam logic [PTR_W-1:0] PTR_ONE = 7'h01;
    localparam logic [PTR_W-1:0] PTR_FULL = 7'h40;
endpackage : useq_stack_pkg

// ===== tb/useq_pipe_model.sv
// Pipeline register and status model feeding the sequencer controls
`timescale 1ns/1ns
module useq_pipe_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] src_i,
    input wire logic [2:0] op_i,
    input wire logic [4:0] flags_i,
    input wire logic link_n_i,
    input wire logic yoe_n_i,
    output logic [2:0] src_o,
    output logic [2:0] op_o,
    output logic output_select_flag_o,
    output logic cc_o,
    output logic dec_o,
    output logic zero_o,
    output logic inc_o,
    output logic link_n_o,
    output logic yoe_n_o
);
    ////////////////////////////////////////////////////////////////////////
    // Condition and increment are registered in the same stage as the
    // microword fields, so all controls reach the sequencer together
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {src_o, op_o, output_select_flag_o, cc_o, dec_o, zero_o, inc_o, link_n_o,
                yoe_n_o} <= {6'h07, 4'h4, 3'h6};
        end else begin
            {src_o, op_o, output_select_flag_o, cc_o, dec_o, zero_o, inc_o, link_n_o,
                yoe_n_o} <= {src_i, op_i, flags_i, link_n_i, yoe_n_i};
        end
    end
endmodule : useq_pipe_model

// ===== tb/useq_stack_test.sv
// Self-checking bench for the call/return stack sequencer
`timescale 1ns/1ns
module useq_stack_test;
    import useq_stack_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [12:0] w = {6'h07, 4'h4, 3'h6};
    logic [2:0] p_src, p_op;
    logic p_output_select_flag, p_cc, p_dec, p_zero, p_inc, p_link, p_yoe;
    logic lk = 1'b1, yo = 1'b0;
    logic [15:0] a_v = 16'h0000, a_out, y;
    logic a_oe, y_oe, warn, ack, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dat;
    int err_count = 0, num_checks = 0;

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    useq_pipe_model partner (.clk_i(clk_i), .rst_i(rst_i),
        .src_i(w[12:10]), .op_i(w[9:7]), .flags_i(w[6:2]),
        .link_n_i(w[1]), .yoe_n_i(w[0]), .src_o(p_src), .op_o(p_op),
        .output_select_flag_o(p_output_select_flag), .cc_o(p_cc), .dec_o(p_dec), .zero_o(p_zero),
        .inc_o(p_inc), .link_n_o(p_link), .yoe_n_o(p_yoe));

    useq_stack DUT (.clk_i(clk_i), .rst_i(rst_i),
        .next_source_select_i(p_src), .stack_op_code_i(p_op),
        .output_select_flag_i(p_output_select_flag), .cond_code_n_i(p_cc),
        .counter_dec_i(p_dec), .counter_zero_i(p_zero),
        .inc_ctrl_i(p_inc), .int_link_n_i(p_link),
        .status_nibble_in_i(4'h5), .data_port_a_i(a_v),
        .data_port_a_o(a_out), .data_port_a_oe_o(a_oe),
        .data_port_b_i(16'h4560), .addr_out_enable_n_i(p_yoe),
        .next_addr_i(16'h0800), .next_addr_o(y), .next_addr_oe_o(y_oe),
        .stack_warn_read_err_o(warn), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat),
        .ack_o(ack));

    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task chk(input string nm, input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task wb(input logic wr, input logic [3:0] ad, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'h3, wr, ad, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            err_count++;
            report_and_stop();
        end
        rdat = dat;
        {cyc, stb} <= 2'h0;
    endtask : wb

    task st(input logic [6:0] es, er);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("sp", rdat[6:0], es);
        chk("rp", rdat[14:8], er);
    endtask : st

    // Setup word, then the microword, then setup again; the setup word
    // branches to A so the next continue yields A plus increment
    task ins(input logic [2:0] s, o, input logic [4:0] f,
             input logic [15:0] av, ey);
        @(posedge clk_i);
        a_v <= av;
        w <= {6'h07, 4'h4, f[0], 2'h2};
        @(posedge clk_i);
        w <= {s, o, f, lk, yo};
        @(posedge clk_i);
        w <= {6'h07, 4'h4, f[0], 2'h2};
        #1;
        if (yo) begin
            chk("next_addr_oe", y_oe, 32'h0);
        end else begin
            chk("next_addr", y, ey);
        end
    endtask : ins

    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", rdat[6:0], CTRL_RESET);
        st(7'h00, 7'h00);
        wb(1'b1, REG_CTRL, 32'h3);
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", rdat[6:0], 7'h03);
        wb(1'b0, 4'h8, 32'h0);
        chk("unmapped", rdat, 32'h0);
        wb(1'b1, REG_CTRL, 32'h0);
    endtask : t_regs

    task t_calls;
        ins(3'h4, 3'h5, 5'h01, 16'h1000, 16'h1000);
        ins(3'h4, 3'h5, 5'h09, 16'h1100, 16'h4560);
        st(7'h01, 7'h01);
        ins(3'h6, 3'h7, 5'h19, 16'h1200, 16'h1201);
        chk("warn", warn, 32'h1);
        @(posedge clk_i);
        #1;
        chk("read_data", a_out, 32'h1001);
        chk("read_oe", a_oe, 32'h1);
        st(7'h01, 7'h00);
        ins(3'h6, 3'h6, 5'h09, 16'h1300, 16'h1301);
        st(7'h02, 7'h02);
        ins(3'h1, 3'h6, 5'h01, 16'h1400, 16'h1301);
        ins(3'h5, 3'h7, 5'h01, 16'h1560, 16'h1565);
        ins(3'h5, 3'h7, 5'h09, 16'h1560, 16'h4565);
        ins(3'h2, 3'h5, 5'h07, 16'h1700, 16'h1700);
        ins(3'h0, 3'h5, 5'h06, 16'h1800, 16'h1800);
        st(7'h03, 7'h03);
    endtask : t_calls

    task t_returns;
        ins(3'h0, 3'h3, 5'h01, 16'h1900, 16'h1401);
        ins(3'h1, 3'h3, 5'h09, 16'h1900, 16'h4560);
        st(7'h02, 7'h02);
        ins(3'h2, 3'h3, 5'h07, 16'h1A00, 16'h1A00);
        ins(3'h2, 3'h3, 5'h05, 16'h1A00, 16'h1301);
        st(7'h01, 7'h01);
    endtask : t_returns

    task t_continue;
        ins(3'h6, 3'h4, 5'h09, 16'h1B00, 16'h1B01);
        ins(3'h6, 3'h7, 5'h09, 16'h1B00, 16'h1B01);
        st(7'h02, 7'h02);
        ins(3'h6, 3'h2, 5'h09, 16'h1B00, 16'h1B01);
        st(7'h01, 7'h01);
        ins(3'h0, 3'h7, 5'h09, 16'h2020, 16'h2020);
    endtask : t_continue

    task t_clear;
        ins(3'h4, 3'h1, 5'h01, 16'h1C00, 16'h1C00);
        st(7'h00, 7'h00);
    endtask : t_clear

    task t_int;
        yo = 1'b1;
        ins(3'h4, 3'h5, 5'h01, 16'h1D00, 16'h0000);
        yo = 1'b0;
        lk = 1'b0;
        ins(3'h6, 3'h4, 5'h09, 16'h1E00, 16'h1E01);
        lk = 1'b1;
        st(7'h02, 7'h02);
        ins(3'h6, 3'h7, 5'h19, 16'h1E10, 16'h1E11);
        @(posedge clk_i);
        #1;
        chk("int_return", a_out, 32'h1D00);
        ins(3'h4, 3'h0, 5'h09, 16'h1F00, 16'h0000);
        st(7'h00, 7'h00);
    endtask : t_int

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_calls();
        t_returns();
        t_continue();
        t_clear();
        t_int();
        report_and_stop();
    end
endmodule : useq_stack_test
